//--- rtl/compare_timer_event_pulse.sv
// Compare timer: event counting and programmable pulse generation.
// Assumes an Avalon-MM master on clk and an asynchronous trigger pin.
//
// Local design decisions: the Avalon-MM register port and the register offsets.
`include "ctimer_defs.svh"
module compare_timer_event_pulse
	import ctimer_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic trigger_input_pin,
	output logic pulse_output_pin,
	output logic match_interrupt
);
	timer_control_one_t ctrl1_ff;
	timer_control_two_t ctrl2_ff;
	logic [15:0] cmp_a_ff;
	logic [15:0] cmp_b_ff;
	logic [15:0] cmp_c_ff;
	logic [15:0] cnt_ff;
	logic [15:0] nxt_cnt;
	logic [1:0] pre_ff;
	logic [1:0] nxt_pre;
	run_state_t state_ff;
	run_state_t nxt_state;
	logic out_ff;
	logic nxt_out;
	logic irq_ff;
	logic nxt_irq;
	logic waitreq_ff;
	logic [31:0] rdata_ff;
	logic [31:0] rd_mux;
	logic [2:0] reg_idx;
	logic wr_fire;
	logic start_ev;
	trig_edges_t edges;
	logic sel_edge;
	logic opp_edge;
	logic trig_active;
	logic [2:0] ratio;
	logic tick;
	logic [15:0] max_val;
	logic hit_any;
	logic use_b;
	logic use_c;

	trig_sync u_sync (
		.clk(clk),
		.rstn(rstn),
		.ce(ce),
		.pin(trigger_input_pin),
		.edges(edges)
	);

	assign reg_idx = avs_address[4:2];
	assign wr_fire = ce && avs_write && !waitreq_ff;

	// One wait cycle per access, so read data comes from a register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			waitreq_ff <= 1'b1;
		end else if (ce) begin
			waitreq_ff <= !((avs_read || avs_write) && waitreq_ff);
		end
	end

	always_comb begin
		rd_mux = 32'h00000000;
		if (reg_idx == `CT_ADDR_CTRL1) begin
			rd_mux[`CT_C1_W-1:0] = ctrl1_ff;
		end else if (reg_idx == `CT_ADDR_CTRL2) begin
			rd_mux[`CT_C2_W-1:0] = ctrl2_ff;
		end else if (reg_idx == `CT_ADDR_CMPA) begin
			rd_mux[15:0] = cmp_a_ff;
		end else if (reg_idx == `CT_ADDR_CMPB) begin
			rd_mux[15:0] = cmp_b_ff;
		end else if (reg_idx == `CT_ADDR_CMPC) begin
			rd_mux[15:0] = cmp_c_ff;
		end else if (reg_idx == `CT_ADDR_STAT) begin
			rd_mux[15:0] = cnt_ff;
			rd_mux[`CT_ST_RUN_BIT] = (state_ff == ST_RUN);
			rd_mux[`CT_ST_OUT_BIT] = out_ff;
			rd_mux[`CT_ST_PIN_BIT] = edges.level;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata_ff <= 32'h00000000;
		end else if (ce && avs_read && waitreq_ff) begin
			rdata_ff <= rd_mux;
		end
	end

	// Count field picks which compare registers take part
	assign use_b = ctrl2_ff.register_count_field == 2'h1 ||
		ctrl2_ff.register_count_field == 2'h2;
	assign use_c = ctrl2_ff.register_count_field == 2'h2;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl1_ff <= `CT_C1_RST;
			ctrl2_ff <= `CT_C2_RST;
		end else if (wr_fire) begin
			if (reg_idx == `CT_ADDR_CTRL1) begin
				ctrl1_ff <= avs_writedata[`CT_C1_W-1:0];
			end else if (reg_idx == `CT_ADDR_CTRL2) begin
				ctrl2_ff <= avs_writedata[`CT_C2_W-1:0];
			end
		end
	end

	// No shadowing: software must time compare updates itself
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cmp_a_ff <= `CT_CMP_RST;
			cmp_b_ff <= `CT_CMP_RST;
			cmp_c_ff <= `CT_CMP_RST;
		end else if (wr_fire) begin
			if (reg_idx == `CT_ADDR_CMPA) begin
				cmp_a_ff <= avs_writedata[15:0];
			end else if (reg_idx == `CT_ADDR_CMPB) begin
				if (ctrl1_ff.mode == MODE_PULSE && use_b) begin
					cmp_b_ff <= avs_writedata[15:0];
				end
			end else if (reg_idx == `CT_ADDR_CMPC) begin
				if (ctrl1_ff.mode == MODE_PULSE && use_c) begin
					cmp_c_ff <= avs_writedata[15:0];
				end
			end
		end
	end

	assign start_ev = wr_fire && reg_idx == `CT_ADDR_CTRL1 &&
		avs_writedata[`CT_C1_START_BIT] && avs_writedata[1:0] == MODE_PULSE;
	assign sel_edge = ctrl1_ff.trigger_edge_select ? edges.fall : edges.rise;
	assign opp_edge = ctrl1_ff.trigger_edge_select ? edges.rise : edges.fall;
	// Output-mode pin or disable bit shuts trigger edges out
	assign trig_active = !ctrl2_ff.ext_trigger_disable && !ctrl2_ff.trigger_pin_output;

	// Undefined clock codes give no tick, so the counter holds
	always_comb begin
		ratio = 3'h0;
		if (ctrl1_ff.clock_select_field == `CT_CK_SLOW) begin
			ratio = `CT_DIV_SLOW;
		end else if (ctrl1_ff.clock_select_field == `CT_CK_FAST) begin
			ratio = ctrl1_ff.divider_select_bit ? `CT_DIV_SLOW : `CT_DIV_FAST;
		end
	end
	assign tick = (ratio != 3'h0) && (pre_ff == ratio[1:0] - 2'h1);

	always_comb begin
		max_val = cmp_a_ff;
		if (use_c) begin
			max_val = cmp_c_ff;
		end else if (use_b) begin
			max_val = cmp_b_ff;
		end
	end
	assign hit_any = (cnt_ff == cmp_a_ff) || (use_b && cnt_ff == cmp_b_ff) ||
		(use_c && cnt_ff == cmp_c_ff);

	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_state = state_ff;
		nxt_out = out_ff;
		nxt_irq = 1'b0;
		nxt_pre = pre_ff;
		if (state_ff == ST_RUN && ratio != 3'h0) begin
			nxt_pre = tick ? 2'h0 : pre_ff + 2'h1;
		end
		case (ctrl1_ff.mode)
			MODE_EVENT: begin
				nxt_state = ST_IDLE;
				// Match checked on the edge opposite the counting edge
				if (opp_edge && cnt_ff == cmp_a_ff) begin
					nxt_cnt = 16'h0000;
					nxt_irq = 1'b1;
				end else if (sel_edge) begin
					nxt_cnt = cnt_ff + 16'h0001;
				end
			end
			MODE_PULSE: begin
				if (state_ff == ST_IDLE) begin
					nxt_out = ctrl2_ff.output_initial_level;
				end
				if (start_ev || (trig_active && sel_edge)) begin
					nxt_cnt = 16'h0000;
					nxt_pre = 2'h0;
					nxt_state = ST_RUN;
				end else if (trig_active && opp_edge && ctrl1_ff.both_edge_enable) begin
					nxt_cnt = 16'h0000;
					nxt_pre = 2'h0;
					nxt_state = ST_IDLE;
				end else if (state_ff == ST_RUN && tick) begin
					if (cnt_ff == max_val) begin
						nxt_cnt = 16'h0000;
						nxt_irq = 1'b1;
						nxt_out = !out_ff;
						if (ctrl1_ff.one_shot) begin
							nxt_state = ST_IDLE;
						end
					end else begin
						nxt_cnt = cnt_ff + 16'h0001;
						if (hit_any) begin
							nxt_out = !out_ff;
						end
					end
				end
			end
			default: begin
				nxt_state = ST_IDLE;
				nxt_cnt = 16'h0000;
				nxt_pre = 2'h0;
			end
		endcase
		// A start written together with the mode switch must not be lost
		if (start_ev && ctrl1_ff.mode != MODE_PULSE) begin
			nxt_cnt = 16'h0000;
			nxt_pre = 2'h0;
			nxt_out = ctrl2_ff.output_initial_level;
			nxt_state = ST_RUN;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_ff <= 16'h0000;
			pre_ff <= 2'h0;
			state_ff <= ST_IDLE;
		end else if (ce) begin
			cnt_ff <= nxt_cnt;
			pre_ff <= nxt_pre;
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			out_ff <= 1'b0;
			irq_ff <= 1'b0;
		end else if (ce) begin
			out_ff <= nxt_out;
			irq_ff <= nxt_irq;
		end
	end

	assign avs_readdata = rdata_ff;
	assign avs_waitrequest = waitreq_ff;
	assign pulse_output_pin = out_ff;
	assign match_interrupt = irq_ff;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn || !ce);

	property p_evt_count;
		ctrl1_ff.mode == MODE_EVENT && sel_edge && !start_ev && ce ##1 ce |->
			cnt_ff == 16'($past(cnt_ff) + 16'h0001);
	endproperty
	a_evt_count: assert property (p_evt_count)
		else $error("event count did not step on active edge");

	property p_evt_match;
		ctrl1_ff.mode == MODE_EVENT && opp_edge && cnt_ff == cmp_a_ff && !start_ev && ce |=>
			match_interrupt && cnt_ff == 16'h0000;
	endproperty
	a_evt_match: assert property (p_evt_match)
		else $error("event match gave no interrupt or clear");

	property p_toggle;
		ctrl1_ff.mode == MODE_PULSE && state_ff == ST_RUN && tick && hit_any && ce &&
			!start_ev && !(trig_active && (sel_edge || opp_edge)) |=>
			pulse_output_pin != $past(pulse_output_pin);
	endproperty
	a_toggle: assert property (p_toggle)
		else $error("pulse output missed a toggle on match");

	property p_irq_cause;
		match_interrupt |-> $past(ctrl1_ff.mode == MODE_EVENT ||
			(state_ff == ST_RUN && tick && cnt_ff == max_val));
	endproperty
	a_irq_cause: assert property (p_irq_cause)
		else $error("interrupt without final compare match");

	property p_preload;
		ctrl1_ff.mode == MODE_PULSE && state_ff == ST_IDLE && ce |=>
			pulse_output_pin == $past(ctrl2_ff.output_initial_level);
	endproperty
	a_preload: assert property (p_preload)
		else $error("idle output not preloaded from initial level");

	property p_wr_b_block;
		wr_fire && reg_idx == `CT_ADDR_CMPB && !use_b |=> $stable(cmp_b_ff);
	endproperty
	a_wr_b_block: assert property (p_wr_b_block)
		else $error("compare B written while not enabled");

	property p_both_stop;
		ctrl1_ff.mode == MODE_PULSE && trig_active && opp_edge && !sel_edge &&
			ctrl1_ff.both_edge_enable && !start_ev && ce |=>
			state_ff == ST_IDLE && cnt_ff == 16'h0000;
	endproperty
	a_both_stop: assert property (p_both_stop)
		else $error("opposite edge did not stop counter");

	property p_one_shot;
		ctrl1_ff.mode == MODE_PULSE && ctrl1_ff.one_shot && state_ff == ST_RUN && tick &&
			cnt_ff == max_val && !start_ev && !(trig_active && (sel_edge || opp_edge)) |=>
			state_ff == ST_IDLE && cnt_ff == 16'h0000 && match_interrupt;
	endproperty
	a_one_shot: assert property (p_one_shot)
		else $error("one-shot did not clear and stop");

	property p_tick_gap;
		tick && state_ff == ST_RUN && ce |=> !tick;
	endproperty
	a_tick_gap: assert property (p_tick_gap)
		else $error("prescaler ticked on consecutive cycles");

	property p_wr_c_block;
		wr_fire && reg_idx == `CT_ADDR_CMPC && !(ctrl1_ff.mode == MODE_PULSE && use_c) |=>
			$stable(cmp_c_ff);
	endproperty
	a_wr_c_block: assert property (p_wr_c_block)
		else $error("compare C written while not enabled");

	property p_start;
		start_ev |=> state_ff == ST_RUN && cnt_ff == 16'h0000;
	endproperty
	a_start: assert property (p_start)
		else $error("start command did not launch the counter");

	property p_trig_blocked;
		ctrl1_ff.mode == MODE_PULSE && state_ff == ST_IDLE && !trig_active && !start_ev |=>
			state_ff == ST_IDLE;
	endproperty
	a_trig_blocked: assert property (p_trig_blocked)
		else $error("blocked trigger started the counter");

	property p_wrap;
		ctrl1_ff.mode == MODE_PULSE && !ctrl1_ff.one_shot && state_ff == ST_RUN && tick &&
			cnt_ff == max_val && !start_ev && !(trig_active && (sel_edge || opp_edge)) |=>
			state_ff == ST_RUN && cnt_ff == 16'h0000 && match_interrupt;
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("successive run did not wrap to zero");
endmodule : compare_timer_event_pulse

//--- rtl/ctimer_defs.svh
// Offsets, field positions, reset values and divide counts of the compare timer.
// Assumes a 32-bit Avalon-MM slave with byte addresses; included by the package and the top.
// Function
// - Event mode: count once per selected trigger edge, polarity from edge select bit.
// - Event mode: on compare A equality raise interrupt, clear, keep counting.
// - Pulse mode starts on software command or trigger edge, counts prescaled clock.
// - Edge select picks start polarity; both-edge bit makes opposite edge act.
// - Pulse output toggles on every match with any active compare register.
// - Pulse mode interrupt only on match with highest enabled compare register.
// - Reset forces pulse output flip-flop to zero.
// - Initial-level bit preloads pulse output, choosing high or low pulses.
// - Writes to compare B and C ignored unless pulse mode enables them.
// - Count field: 00 uses A, 01 uses A and B, 10 uses A, B, C.
// - Count field may change while pulse generation runs.
// - Enabled trigger input edges reset the counter; disable bit or output blocks them.
// - Code 100 divides by four; code 101 divides by two, or four with divider.
// - Both-edge set: opposite edge clears and stops counter; clear: ignored.
// - One-shot: after final match and interrupt, counter clears and waits for start.
`ifndef CTIMER_DEFS_SVH
`define CTIMER_DEFS_SVH
`define CT_ADDR_CTRL1 3'h0
`define CT_ADDR_CTRL2 3'h1
`define CT_ADDR_CMPA 3'h2
`define CT_ADDR_CMPB 3'h3
`define CT_ADDR_CMPC 3'h4
`define CT_ADDR_STAT 3'h5
`define CT_C1_W 9
`define CT_C1_START_BIT 9
`define CT_C2_W 5
`define CT_C1_RST 9'h000
`define CT_C2_RST 5'h00
`define CT_CMP_RST 16'h0000
`define CT_CNT_W 16
`define CT_ST_RUN_BIT 16
`define CT_ST_OUT_BIT 17
`define CT_ST_PIN_BIT 18
`define CT_CK_SLOW 3'h4
`define CT_CK_FAST 3'h5
`define CT_DIV_SLOW 3'h4
`define CT_DIV_FAST 3'h2
`endif

//--- rtl/ctimer_pkg.sv
// Types shared by the compare timer files.
// Assumes ctimer_defs.svh sits in the include path.
`include "ctimer_defs.svh"
package ctimer_pkg;
	typedef enum logic [1:0] {
		MODE_OFF = 2'h0,
		MODE_EVENT = 2'h1,
		MODE_PULSE = 2'h2,
		MODE_RSVD = 2'h3
	} mode_t;
	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_RUN = 1'b1
	} run_state_t;
	typedef struct packed {
		logic divider_select_bit;
		logic [2:0] clock_select_field;
		logic one_shot;
		logic both_edge_enable;
		logic trigger_edge_select;
		mode_t mode;
	} timer_control_one_t;
	typedef struct packed {
		logic trigger_pin_output;
		logic ext_trigger_disable;
		logic output_initial_level;
		logic [1:0] register_count_field;
	} timer_control_two_t;
	typedef struct packed {
		logic rise;
		logic fall;
		logic level;
	} trig_edges_t;
endpackage : ctimer_pkg

//--- rtl/trig_sync.sv
// Three-stage synchroniser and edge finder for the trigger pin.
// Assumes the pin is asynchronous to clk; ce freezes it with the rest of the block.
module trig_sync
	import ctimer_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic pin,
	output trig_edges_t edges
);
	logic s1_ff;
	logic s2_ff;
	logic s3_ff;
	logic lvl_ff;
	trig_edges_t edges_ff;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s1_ff <= 1'b0;
			s2_ff <= 1'b0;
			s3_ff <= 1'b0;
		end else if (ce) begin
			s1_ff <= pin;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// Change only counts once two late stages agree
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lvl_ff <= 1'b0;
			edges_ff <= '0;
		end else if (ce) begin
			edges_ff.rise <= (s2_ff == s3_ff) && s3_ff && !lvl_ff;
			edges_ff.fall <= (s2_ff == s3_ff) && !s3_ff && lvl_ff;
			edges_ff.level <= lvl_ff;
			if (s2_ff == s3_ff) begin
				lvl_ff <= s3_ff;
			end
		end
	end

	assign edges = edges_ff;
endmodule : trig_sync

//--- sim/test_compare_timer_event_pulse.sv
// Self-checking bench for the compare timer, with an integer reference model.
// Assumes trig_source drives the trigger pin; ce high except in the clock-enable test.
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
	$display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module test_compare_timer_event_pulse import ctimer_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rstn, ce, avs_read, avs_write, avs_waitrequest;
	logic prev_out = 1'b0;
	logic [4:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic trigger_input_pin, pulse_output_pin, match_interrupt;
	int errors = 0, cmp_count = 0, irq_cnt = 0, tog_cnt = 0;
	int a, b, c, top, nreg, div, ckc, n, t0, g0, m_cnt, m_irq;
	compare_timer_event_pulse compare_timer_event_pulse_inst (.clk(clk), .rstn(rstn),
		.ce(ce), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .trigger_input_pin(trigger_input_pin),
		.pulse_output_pin(pulse_output_pin), .match_interrupt(match_interrupt));
	trig_source trig_source_inst (.clk(clk), .pin(trigger_input_pin));
	always #20 clk = ~clk;
	always @(posedge clk) begin
		if (match_interrupt === 1'b1) irq_cnt++;
		if (pulse_output_pin !== prev_out) tog_cnt++;
		prev_out <= pulse_output_pin;
	end
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : wrap_up
	// Request held until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input int idx, input logic [31:0] wd);
		int k;
		@(posedge clk);
		avs_address <= 5'(idx * 4);
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= wd;
		k = 0;
		do begin @(posedge clk); k++; end while (avs_waitrequest !== 1'b0 && k < 50);
		if (k >= 50) begin errors++; wrap_up(); end
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	task automatic wait_irq(output int cnt);
		cnt = 0;
		do begin @(posedge clk); cnt++; end while (match_interrupt !== 1'b1 && cnt < 3000);
		if (cnt >= 3000) begin errors++; wrap_up(); end
		#1;
	endtask : wait_irq
	task automatic model_event(input int p, input int a, input int n, inout int cnt, inout int irq);
		for (int i = 0; i < 2 * n; i++) begin
			if ((i % 2) == p) cnt++;
			else if (cnt == a) begin cnt = 0; irq++; end
		end
	endtask : model_event
	function automatic logic [31:0] c1(int md, int ed, int bo, int os, int ck, int dv, int st);
		return {22'h0, 1'(st), 1'(dv), 3'(ck), 1'(os), 1'(bo), 1'(ed), 2'(md)};
	endfunction : c1
	task automatic end_test(input string s);
		$display("test %s done", s);
	endtask : end_test
	initial begin
		clk = 1'b0;
		rstn = 1'b0;
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		ce = 1'b1;
		void'($urandom(32'h863E));
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		`CHK("pin", 1'b0, pulse_output_pin)
		for (int i = 0; i < 8; i++) begin
			bus(0, i, 0);
			`CHK("reset_reg", 32'h0, rd)
		end
		bus(1, 3, 32'h1234);
		bus(0, 3, 0);
		`CHK("cmp_b_off", 32'h0, rd)
		bus(1, 7, 32'hFF);
		bus(0, 7, 0);
		`CHK("unmapped", 32'h0, rd)
		bus(1, 0, c1(2, 0, 0, 0, 4, 0, 0));
		bus(1, 1, 32'h9);
		bus(1, 3, 32'h1234);
		bus(1, 4, 32'h5678);
		bus(0, 3, 0);
		`CHK("cmp_b_on", 32'h1234, rd)
		bus(0, 4, 0);
		`CHK("cmp_c_off", 32'h0, rd)
		end_test("registers");
		m_cnt = 0;
		for (int p = 0; p < 2; p++) begin
			a = 2 + $urandom_range(3);
			bus(1, 2, 32'(a));
			bus(1, 0, c1(1, p, 0, 0, 0, 0, 0));
			g0 = irq_cnt;
			m_irq = 0;
			model_event(p, a, 3 * a + 1, m_cnt, m_irq);
			trig_source_inst.pulses(3 * a + 1, 5);
			bus(0, 5, 0);
			`CHK("ev_count", m_cnt, rd[15:0])
			`CHK("ev_irq", m_irq, irq_cnt - g0)
		end
		end_test("event");
		a = 3 + $urandom_range(3);
		b = a + 2 + $urandom_range(3);
		c = b + 2 + $urandom_range(3);
		bus(1, 1, 32'hA);
		// Pulse mode first, else compare B and C writes are dropped
		bus(1, 0, c1(2, 0, 0, 0, 4, 0, 0));
		bus(1, 2, 32'(a));
		bus(1, 3, 32'(b));
		bus(1, 4, 32'(c));
		bus(1, 0, c1(2, 0, 0, 0, 4, 0, 1));
		// Reconfigured while running, right after a period end
		for (int k = 0; k < 12; k++) begin
			top = (k % 4 == 1) ? b : (k % 4 == 2) ? c : a;
			nreg = (k % 4 == 1) ? 2 : (k % 4 == 2) ? 3 : 1;
			ckc = (k / 4 == 0) ? 4 : 5;
			div = (k / 4 == 1) ? 2 : 4;
			bus(1, 1, 32'(8 + k % 4));
			bus(1, 0, c1(2, 0, 0, 0, ckc, k / 4 == 2, 0));
			wait_irq(n);
			t0 = tog_cnt;
			wait_irq(n);
			`CHK("period", (top + 1) * div, n)
			`CHK("toggles", nreg, tog_cnt - t0)
		end
		end_test("pulse");
		bus(1, 2, 32'h3);
		bus(1, 1, 32'hC);
		bus(1, 0, c1(2, 0, 0, 1, 4, 0, 0));
		wait_irq(n);
		repeat (4) @(posedge clk);
		`CHK("init_level", 1'b1, pulse_output_pin)
		bus(1, 0, c1(2, 0, 0, 1, 4, 0, 1));
		wait_irq(n);
		repeat (40) @(posedge clk);
		g0 = irq_cnt;
		bus(0, 5, 0);
		// Stopped and cleared; idle output back at the initial level of one
		`CHK("os_state", 18'h20000, rd[17:0])
		repeat (100) @(posedge clk);
		`CHK("os_irq", 0, irq_cnt - g0)
		end_test("one_shot");
		bus(1, 2, 32'hFF);
		for (int d = 0; d < 2; d++) begin
			bus(1, 1, d ? 32'h10 : 32'h8);
			bus(1, 0, c1(2, 0, 1, 0, 4, 0, 0));
			trig_source_inst.set_level(1'b1);
			bus(0, 5, 0);
			`CHK("blocked", 1'b0, rd[16])
			trig_source_inst.set_level(1'b0);
		end
		bus(1, 1, 32'h0);
		for (int e = 1; e >= 0; e--) begin
			bus(1, 0, c1(2, 0, e, 0, 4, 0, 0));
			trig_source_inst.set_level(1'b1);
			bus(0, 5, 0);
			`CHK("trig_run", 1'b1, rd[16])
			trig_source_inst.set_level(1'b0);
			bus(0, 5, 0);
			`CHK("opp_edge", !e, rd[16])
		end
		// Falling start: a rising edge is now the opposite edge and stops the run
		bus(1, 0, c1(2, 1, 1, 0, 4, 0, 0));
		trig_source_inst.set_level(1'b1);
		bus(0, 5, 0);
		`CHK("fall_opp", 1'b0, rd[16])
		trig_source_inst.set_level(1'b0);
		bus(0, 5, 0);
		`CHK("fall_start", 1'b1, rd[16])
		end_test("trigger");
		// Running at one tick per four clocks; only four live edges between samples
		bus(0, 5, 0);
		g0 = rd[15:0];
		@(posedge clk);
		ce <= 1'b0;
		repeat (200) @(posedge clk);
		ce <= 1'b1;
		bus(0, 5, 0);
		`CHK("ce_hold", 16'h0001, 16'(rd[15:0] - g0))
		end_test("clock_enable");
		wrap_up();
	end
endmodule : test_compare_timer_event_pulse

//--- sim/trig_source.sv
// Behavioural source for the trigger pin of the compare timer.
// Assumes the bench calls its tasks right after a rising edge of clk.
module trig_source (
	input wire logic clk,
	output logic pin
);
	timeunit 1ns;
	timeprecision 1ns;
	initial pin = 1'b0;
	// Every level held 8 clocks, above the four-clock minimum
	task automatic set_level(input logic v);
		@(posedge clk);
		pin <= v;
		repeat (8) @(posedge clk);
	endtask : set_level
	// Whole pulses only; the source never stops mid-pulse
	task automatic pulses(input int n, input int h);
		if (h < 4) h = 4;
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			pin <= 1'b1;
			repeat (h) @(posedge clk);
			pin <= 1'b0;
			repeat (h - 1) @(posedge clk);
		end
		repeat (8) @(posedge clk);
	endtask : pulses
endmodule : trig_source
